/* design/rbt_pkg.sv */
package rbt_pkg;
    // data path width and apb address width
    localparam int RBT_DATA_W = 8;
    localparam int RBT_APB_AW = 12;
    localparam int RBT_FIFO_DEPTH = 8;
    // register byte offsets
    localparam logic [11:0] RBT_OFF_CTRL = 12'h000;
    localparam logic [11:0] RBT_OFF_STATUS = 12'h004;
    localparam logic [11:0] RBT_OFF_LOG = 12'h008;
    // control register fields
    localparam int RBT_CTRL_LOG_EN = 0;
    localparam int RBT_CTRL_CLR_OVF = 1;
    localparam logic RBT_LOG_EN_RST = 1'b0;
    // status register fields
    localparam int RBT_ST_AREG = 0;
    localparam int RBT_ST_BREG = 8;
    localparam int RBT_ST_AVAL = 16;
    localparam int RBT_ST_BVAL = 17;
    localparam int RBT_ST_DRVA = 18;
    localparam int RBT_ST_DRVB = 19;
    localparam int RBT_ST_OVF = 20;
    localparam int RBT_ST_EMPTY = 21;
    localparam int RBT_ST_LEVEL = 24;
    // log word fields
    localparam int RBT_LOG_ENTRY = 0;
    localparam int RBT_LOG_VALID = 31;
    // pins as seen after synchronisation
    typedef struct packed {
        logic [RBT_DATA_W-1:0] aBus;
        logic [RBT_DATA_W-1:0] bBus;
        logic aCapClk;
        logic bCapClk;
        logic outEnN;
        logic dir;
        logic aSel;
        logic bSel;
    } rbt_pins_t;
    // outputs float after reset
    localparam rbt_pins_t RBT_PINS_RST = '{aBus: '0, bBus: '0, aCapClk: 1'b0, bCapClk: 1'b0,
                                           outEnN: 1'b1, dir: 1'b0, aSel: 1'b0, bSel: 1'b0};
    // one capture event as logged
    typedef struct packed {
        logic bCap;
        logic aCap;
        logic [RBT_DATA_W-1:0] bData;
        logic [RBT_DATA_W-1:0] aData;
    } rbt_log_t;
    localparam int RBT_LOG_W = $bits(rbt_log_t);
endpackage

/* design/rbt_transceiver.sv */
// Function
// - eight bits per bus and register
// - capture clocks load their side register
// - capture ignores enable and direction
// - enable high floats both buses
// - isolation still captures either or both
// - direction picks driven bus
// - a port shows live b or stored
// - b port shows live a or stored
// - capture undriven port while driving
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module rbt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed
    logic [PW-1:0] wrPtr_reg, wrPtr_next;
    logic [PW-1:0] rdPtr_reg, rdPtr_next;
    logic [PW:0] count_reg, count_next;
    logic push, pop;

    // honest flags straight from the count
    assign inReady = (count_reg != DEPTH_C);
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign level = count_reg;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // pointer wrap works for any depth, not only powers of two
    always_comb begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (push) begin
            wrPtr_next = (wrPtr_reg == LAST_C) ? '0 : wrPtr_reg + 1'b1;
        end
        if (pop) begin
            rdPtr_next = (rdPtr_reg == LAST_C) ? '0 : rdPtr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // pointer and count state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // data array write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule // rbt_fifo

module rbt_transceiver
    import rbt_pkg::*;
#(
    parameter int FIFO_DEPTH = RBT_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus a pins
    input wire logic [RBT_DATA_W-1:0] aBusIn,
    output logic [RBT_DATA_W-1:0] aBusOut,
    output logic aBusOeN,
    // bus b pins
    input wire logic [RBT_DATA_W-1:0] bBusIn,
    output logic [RBT_DATA_W-1:0] bBusOut,
    output logic bBusOeN,
    // control pins
    input wire logic aSideCaptureClock,
    input wire logic bSideCaptureClock,
    input wire logic outEnN,
    input wire logic dir,
    input wire logic aPortSourceSelect,
    input wire logic bPortSourceSelect,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [RBT_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    rbt_pins_t pinsRaw;                 // raw pin bundle
    rbt_pins_t s1_reg, s2_reg, s3_reg;  // three stage synchroniser
    rbt_pins_t filt_reg, filt_next;     // settled pin levels
    logic aEdge, bEdge;                 // capture clock rises
    logic [RBT_DATA_W-1:0] aSide_reg;   // loads bus a, drives b
    logic [RBT_DATA_W-1:0] bSide_reg;   // loads bus b, drives a
    logic aVal_reg, aVal_next;          // a-side holds data
    logic bVal_reg, bVal_next;          // b-side holds data
    logic [RBT_DATA_W-1:0] aOut_next, bOut_next;
    logic aOeN_next, bOeN_next;
    logic driveA, driveB;
    logic logEn_reg, logEn_next;
    logic ovf_reg, ovf_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    rbt_log_t logIn, logOut;
    logic logPush, logReady, logValid, logPop;
    logic [LW-1:0] logLevel;
    logic setup, access, wrCtrl;

    assign pinsRaw = '{aBus: aBusIn, bBus: bBusIn, aCapClk: aSideCaptureClock,
                       bCapClk: bSideCaptureClock, outEnN: outEnN, dir: dir,
                       aSel: aPortSourceSelect, bSel: bPortSourceSelect};

    // a bit settles once stages two and three agree; s1 feeds only s2
    always_comb begin
        filt_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
    end

    // synchroniser and settled levels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= RBT_PINS_RST;
            s2_reg <= RBT_PINS_RST;
            s3_reg <= RBT_PINS_RST;
            filt_reg <= RBT_PINS_RST;
        end else begin
            s1_reg <= pinsRaw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    // edges are never gated by enable or direction
    assign aEdge = filt_next.aCapClk && !filt_reg.aCapClk;
    assign bEdge = filt_next.bCapClk && !filt_reg.bCapClk;

    // storage stays unknown until its first capture
    always_ff @(posedge clk) begin
        if (aEdge) begin
            aSide_reg <= filt_next.aBus;
        end
        if (bEdge) begin
            bSide_reg <= filt_next.bBus;
        end
    end

    // valid flags tell software when storage is meaningful
    always_comb begin
        aVal_next = aVal_reg | aEdge;
        bVal_next = bVal_reg | bEdge;
    end

    // output steering from settled controls
    always_comb begin
        driveA = !filt_reg.outEnN && !filt_reg.dir;
        driveB = !filt_reg.outEnN && filt_reg.dir;
        aOeN_next = !driveA;
        bOeN_next = !driveB;
        // undriven port still follows its source every cycle; harmless while floating
        aOut_next = filt_reg.aSel ? bSide_reg : filt_reg.bBus;
        bOut_next = filt_reg.bSel ? aSide_reg : filt_reg.aBus;
    end

    // output registers; enables reset to floating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aBusOut <= '0;
            bBusOut <= '0;
            aBusOeN <= 1'b1;
            bBusOeN <= 1'b1;
            aVal_reg <= 1'b0;
            bVal_reg <= 1'b0;
        end else begin
            aBusOut <= aOut_next;
            bBusOut <= bOut_next;
            aBusOeN <= aOeN_next;
            bBusOeN <= bOeN_next;
            aVal_reg <= aVal_next;
            bVal_reg <= bVal_next;
        end
    end

    // capture log; a full fifo drops the entry, never the capture
    assign logIn = '{bCap: bEdge, aCap: aEdge, bData: filt_next.bBus, aData: filt_next.aBus};
    assign logPush = logEn_reg && (aEdge || bEdge);

    rbt_fifo #(
        .WIDTH(RBT_LOG_W),
        .DEPTH(FIFO_DEPTH)
    ) u_log (
        .clk(clk),
        .nrst(nrst),
        .inValid(logPush),
        .inReady(logReady),
        .inData(logIn),
        .outValid(logValid),
        .outReady(logPop),
        .outData(logOut),
        .level(logLevel)
    );

    // apb phases; zero wait states
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = err_reg;
    assign wrCtrl = access && pwrite && (paddr == RBT_OFF_CTRL);
    assign logPop = access && !pwrite && (paddr == RBT_OFF_LOG);

    // read data is latched in setup so it comes from a flop
    always_comb begin
        rdata_next = rdata_reg;
        err_next = err_reg;
        logEn_next = logEn_reg;
        // a lost entry in the clear cycle still sets the flag
        ovf_next = (logPush && !logReady) || (ovf_reg && !(wrCtrl && pwdata[RBT_CTRL_CLR_OVF]));
        if (wrCtrl) begin
            logEn_next = pwdata[RBT_CTRL_LOG_EN];
        end
        if (setup) begin
            rdata_next = '0;
            err_next = 1'b0;
            unique case (paddr)
                RBT_OFF_CTRL: begin
                    rdata_next[RBT_CTRL_LOG_EN] = logEn_reg;
                end
                RBT_OFF_STATUS: begin
                    rdata_next[RBT_ST_AREG +: RBT_DATA_W] = aSide_reg;
                    rdata_next[RBT_ST_BREG +: RBT_DATA_W] = bSide_reg;
                    rdata_next[RBT_ST_AVAL] = aVal_reg;
                    rdata_next[RBT_ST_BVAL] = bVal_reg;
                    rdata_next[RBT_ST_DRVA] = !aBusOeN;
                    rdata_next[RBT_ST_DRVB] = !bBusOeN;
                    rdata_next[RBT_ST_OVF] = ovf_reg;
                    rdata_next[RBT_ST_EMPTY] = !logValid;
                    rdata_next[RBT_ST_LEVEL +: LW] = logLevel;
                end
                RBT_OFF_LOG: begin
                    rdata_next[RBT_LOG_ENTRY +: RBT_LOG_W] = logValid ? logOut : '0;
                    rdata_next[RBT_LOG_VALID] = logValid;
                end
                default: begin
                    err_next = 1'b1;
                end
            endcase
        end
    end

    // register file state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
            err_reg <= 1'b0;
            logEn_reg <= RBT_LOG_EN_RST;
            ovf_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            logEn_reg <= logEn_next;
            ovf_reg <= ovf_next;
        end
    end

    // named steps of the steering behaviour
    sequence sIsolate;
        filt_reg.outEnN;
    endsequence
    sequence sDriveA;
        !filt_reg.outEnN && !filt_reg.dir;
    endsequence
    sequence sDriveB;
        !filt_reg.outEnN && filt_reg.dir;
    endsequence

    a_capture_a_load: assert property (@(posedge clk) disable iff (!nrst)
        aEdge |=> aSide_reg == filt_reg.aBus)
        else $error("a-side register missed bus a");
    a_capture_b_load: assert property (@(posedge clk) disable iff (!nrst)
        bEdge |=> bSide_reg == filt_reg.bBus)
        else $error("b-side register missed bus b");
    // rise taken straight from the settled clock, so gating aEdge by the enable would trip it
    a_capture_ungated: assert property (@(posedge clk) disable iff (!nrst)
        (filt_next.aCapClk && !filt_reg.aCapClk && !filt_reg.outEnN) |=> aVal_reg && aSide_reg == filt_reg.aBus)
        else $error("a-side capture lost while driving");
    a_capture_ungated_b: assert property (@(posedge clk) disable iff (!nrst)
        (filt_next.bCapClk && !filt_reg.bCapClk && !filt_reg.outEnN) |=> bVal_reg && bSide_reg == filt_reg.bBus)
        else $error("b-side capture lost while driving");
    a_isolation_float: assert property (@(posedge clk) disable iff (!nrst)
        sIsolate |=> aBusOeN && bBusOeN)
        else $error("bus driven in isolation");
    a_isolation_hold: assert property (@(posedge clk) disable iff (!nrst)
        (filt_reg.outEnN && !aEdge && !bEdge) |=> $stable(aSide_reg) && $stable(bSide_reg))
        else $error("storage changed without edge");
    a_isolation_store: assert property (@(posedge clk) disable iff (!nrst)
        (filt_reg.outEnN && aEdge) ##1 filt_reg.outEnN |-> aSide_reg == filt_reg.aBus)
        else $error("isolation capture failed");
    a_drive_a_only: assert property (@(posedge clk) disable iff (!nrst)
        sDriveA |=> !aBusOeN && bBusOeN)
        else $error("wrong bus driven for low direction");
    a_drive_b_only: assert property (@(posedge clk) disable iff (!nrst)
        sDriveB |=> aBusOeN && !bBusOeN)
        else $error("wrong bus driven for high direction");
    a_a_port_source: assert property (@(posedge clk) disable iff (!nrst)
        sDriveA |=> aBusOut == ($past(filt_reg.aSel) ? $past(bSide_reg) : $past(filt_reg.bBus)))
        else $error("bus a shows wrong source");
    a_b_port_source: assert property (@(posedge clk) disable iff (!nrst)
        sDriveB |=> bBusOut == ($past(filt_reg.bSel) ? $past(aSide_reg) : $past(filt_reg.aBus)))
        else $error("bus b shows wrong source");
    a_drive_capture: assert property (@(posedge clk) disable iff (!nrst)
        (sDriveB ##0 aEdge) |=> aSide_reg == filt_reg.aBus && !bBusOeN)
        else $error("undriven port not captured");
endmodule // rbt_transceiver

/* testbench/rbt_bus_partner.sv */
`timescale 1ns/1ps

module rbt_bus_partner
    import rbt_pkg::*;
(
    // device side of both wires
    input wire logic [RBT_DATA_W-1:0] aBusOut,
    input wire logic aBusOeN,
    input wire logic [RBT_DATA_W-1:0] bBusOut,
    input wire logic bBusOeN,
    // values the far logic wants on each bus
    input wire logic [RBT_DATA_W-1:0] aDrive,
    input wire logic [RBT_DATA_W-1:0] bDrive,
    // resolved wire levels fed back to the device
    output logic [RBT_DATA_W-1:0] aBusIn,
    output logic [RBT_DATA_W-1:0] bBusIn
);
    // far logic backs off while the device drives, so each wire has one driver
    assign aBusIn = (aBusOeN === 1'b0) ? aBusOut : aDrive;
    assign bBusIn = (bBusOeN === 1'b0) ? bBusOut : bDrive;
endmodule // rbt_bus_partner

/* testbench/tb_rbt_transceiver.sv */
`timescale 1ns/1ps

`define RBT_CHK(got, exp, msg) begin nTests++; if ((got) !== (exp)) begin errCount++; \
    $display("Error %0t %s", $time, msg); end end

module tb_rbt_transceiver
    import rbt_pkg::*;
;
    // clock, reset and seed
    logic clk = 1'b0;
    logic nrst = 1'b0;
    integer seed = 32'h416A;
    // control pins
    logic aCap = 1'b0, bCap = 1'b0, outEnN = 1'b1, dir = 1'b0, aSel = 1'b0, bSel = 1'b0;
    // bus wires and far side values
    logic [7:0] aDrive = 8'h00, bDrive = 8'h00, aBusIn, bBusIn, aBusOut, bBusOut;
    logic aBusOeN, bBusOeN;
    // apb
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    // sample strobe, counters, expectation queues
    logic smpReq = 1'b0;
    int errCount = 0, nTests = 0;
    logic [32:0] expQ[$], mskQ[$];
    // bench copy of the storage and of live values
    logic [7:0] aReg, bReg, aLive, bLive;

    always #4 clk = ~clk;

    rbt_transceiver #(.FIFO_DEPTH(RBT_FIFO_DEPTH)) i_rbt_transceiver (
        .clk(clk), .nrst(nrst),
        .aBusIn(aBusIn), .aBusOut(aBusOut), .aBusOeN(aBusOeN),
        .bBusIn(bBusIn), .bBusOut(bBusOut), .bBusOeN(bBusOeN),
        .aSideCaptureClock(aCap), .bSideCaptureClock(bCap), .outEnN(outEnN), .dir(dir),
        .aPortSourceSelect(aSel), .bPortSourceSelect(bSel),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    rbt_bus_partner i_rbt_bus_partner (
        .aBusOut(aBusOut), .aBusOeN(aBusOeN), .bBusOut(bBusOut), .bBusOeN(bBusOeN),
        .aDrive(aDrive), .bDrive(bDrive), .aBusIn(aBusIn), .bBusIn(bBusIn)
    );

    // verdict; leftover expectations mean a result never showed up
    task stopTest();
        if (expQ.size() != 0) errCount++;
        $display("checks %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task note(input logic [32:0] e, input logic [32:0] m);
        expQ.push_back(e);
        mskQ.push_back(m);
    endtask

    // one apb transfer; an idle edge follows so psel is never assigned twice in a step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            errCount++;
            stopTest();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        note(e, m);
        apb(1'b0, a, 32'h0);
    endtask

    // ask the monitor to sample the bus pins once
    task pins(input logic [32:0] e, input logic [32:0] m);
        note(e, m);
        smpReq <= 1'b1;
        @(posedge clk);
        smpReq <= 1'b0;
        @(posedge clk);
    endtask

    // capture pulse, long enough for the pin synchroniser on both levels
    task cap(input logic ca, input logic cb);
        aCap <= ca;
        bCap <= cb;
        wt(5);
        aCap <= 1'b0;
        bCap <= 1'b0;
        wt(5);
    endtask

    // monitor: oldest expectation against each read or pin sample
    always @(posedge clk) begin : mon
        logic [32:0] obs, e, m;
        if ((psel && penable && pready === 1'b1 && !pwrite) || smpReq) begin
            obs = smpReq ? {15'h0, aBusOeN, bBusOeN, bBusOut, aBusOut} : {pslverr, prdata};
            if (expQ.size() == 0) begin
                errCount++;
                $display("Error %0t result without expectation", $time);
            end else begin
                e = expQ.pop_front();
                m = mskQ.pop_front();
                `RBT_CHK(obs & m, e & m, "result differs")
            end
        end
    end

    // hang guard
    initial begin
        wt(20000);
        errCount++;
        $display("Error %0t watchdog ran out", $time);
        stopTest();
    end

    initial begin
        wt(8);
        nrst <= 1'b1;
        wt(6);
        pins(33'h0_0003_0000, 33'h0_0003_0000);
        rd(RBT_OFF_STATUS, 33'h0, 33'h1_000C_0000);
        $display("test reset done");
        // log on so the capture is also recorded
        apb(1'b1, RBT_OFF_CTRL, 32'h1);
        rd(RBT_OFF_CTRL, 33'h1, 33'h1_0000_0003);
        aReg = 8'($random(seed));
        bReg = 8'($random(seed));
        aDrive <= aReg;
        bDrive <= bReg;
        wt(5);
        cap(1'b1, 1'b1);
        pins(33'h0_0003_0000, 33'h0_0003_0000);
        rd(RBT_OFF_STATUS, {13'h0, 2'h0, 2'h3, bReg, aReg}, 33'h1_000F_FFFF);
        rd(RBT_OFF_LOG, {1'b0, 1'b1, 13'h0, 2'h3, bReg, aReg}, 33'h1_8003_FFFF);
        $display("test isolation capture done");
        // every direction and source select, fresh live data each time
        for (int m = 0; m < 4; m++) begin
            aLive = 8'($random(seed));
            bLive = 8'($random(seed));
            aDrive <= aLive;
            bDrive <= bLive;
            outEnN <= 1'b0;
            dir <= m[1];
            aSel <= m[0];
            bSel <= m[0];
            // a released bus shows the far value only after the enable flips, then syncs again
            wt(12);
            if (m[1]) pins({15'h0, 2'h2, (m[0] ? aReg : aLive), 8'h00}, 33'h0_0003_FF00);
            else pins({15'h0, 2'h1, 8'h00, (m[0] ? bReg : bLive)}, 33'h0_0003_00FF);
        end
        $display("test output modes done");
        // capture the undriven port while the other is driven, then show it stored
        for (int d = 0; d < 2; d++) begin
            outEnN <= 1'b0;
            dir <= d[0];
            aSel <= 1'b1;
            bSel <= 1'b1;
            if (d == 0) bReg = 8'($random(seed));
            else aReg = 8'($random(seed));
            aDrive <= aReg;
            bDrive <= bReg;
            // wait until the released port carries far data through the synchroniser
            wt(10);
            cap(d == 1, d == 0);
            if (d == 1) pins({15'h0, 2'h2, aReg, 8'h00}, 33'h0_0003_FF00);
            else pins({15'h0, 2'h1, 8'h00, bReg}, 33'h0_0003_00FF);
        end
        $display("test capture while driving done");
        // back to isolation: both float, storage held
        outEnN <= 1'b1;
        wt(6);
        pins(33'h0_0003_0000, 33'h0_0003_0000);
        rd(RBT_OFF_STATUS, {13'h0, 2'h0, 2'h3, bReg, aReg}, 33'h1_000F_FFFF);
        // nine logged captures against eight slots: overflow sticks until cleared
        repeat (7) cap(1'b1, 1'b0);
        rd(RBT_OFF_STATUS, 33'h0_0810_0000, 33'h1_0FF0_0000);
        apb(1'b1, RBT_OFF_CTRL, 32'h3);
        rd(RBT_OFF_STATUS, 33'h0_0800_0000, 33'h1_0FF0_0000);
        rd(12'h00C, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        $display("test isolation hold done");
        stopTest();
    end
endmodule // tb_rbt_transceiver
